// *** logic/icc_consts.svh ***
`ifndef ICC_CONSTS_SVH
`define ICC_CONSTS_SVH
// ==========================================
// Register map (byte addresses)
`define ICC_CTRL_ADDR 4'h0
`define ICC_DATA_ADDR 4'h4
`define ICC_TIMER_ADDR 4'h8
// ==========================================
// Control field positions
`define ICC_MODE_LSB 0
`define ICC_BNE_BIT 3
`define ICC_OV_BIT 4
`define ICC_CPI_LSB 5
`define ICC_SIDL_BIT 13
`define ICC_TSEL_LSB 10
`define ICC_CTRL_WMASK 16'h3C67
`define ICC_CTRL_RESET 16'h0000
// ==========================================
// Buffer, prescaler and bus response figures
`define ICC_BUF_DEPTH 4
`define ICC_PRESCALE_16 4'hF
`define ICC_PRESCALE_4 4'h3
`define ICC_RESP_OKAY 2'h0
`define ICC_RESP_SLVERR 2'h2
`endif

// *** logic/icc_edge.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "icc_consts.svh"
// ==========================================
// Synchroniser and edge events
module icc_edge (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin,
    output logic rise,
    output logic fall
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else begin
            s1_ff <= pin;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end
    assign rise = s2_ff & ~s3_ff;
    assign fall = ~s2_ff & s3_ff;
endmodule : icc_edge
`default_nettype wire

// *** logic/icc_pkg.sv ***
package icc_pkg;
    typedef enum logic [2:0] {
        ICC_MODE_OFF = 3'h0,
        ICC_MODE_BOTH = 3'h1,
        ICC_MODE_FALL = 3'h2,
        ICC_MODE_RISE = 3'h3,
        ICC_MODE_RISE4 = 3'h4,
        ICC_MODE_RISE16 = 3'h5,
        ICC_MODE_UNUSED = 3'h6,
        ICC_MODE_WAKE = 3'h7
    } icc_mode_type;
    typedef enum logic [2:0] {
        ICC_TSEL_T3 = 3'h0,
        ICC_TSEL_T2 = 3'h1,
        ICC_TSEL_T4 = 3'h2,
        ICC_TSEL_T5 = 3'h3,
        ICC_TSEL_T1 = 3'h4,
        ICC_TSEL_SYS = 3'h7
    } icc_tsel_type;
    typedef struct packed {
        logic [15:0] t1;
        logic [15:0] t2;
        logic [15:0] t3;
        logic [15:0] t4;
        logic [15:0] t5;
    } icc_timers_type;
    typedef struct packed {
        logic sleep;
        logic idle;
    } icc_cpu_type;
endpackage : icc_pkg

// *** logic/icc_top.sv ***
// Contract
// - Code 100 selects timer one, synchronous only
// - Code 011 timer five, 010 timer four
// - Per-interrupt 11: every fourth capture (mode 001 ignores it and interrupts on every capture)
// - Per-interrupt 10: every third capture (mode 001 ignores it and interrupts on every capture)
// - Per-interrupt 01: every second capture (mode 001 ignores it and interrupts on every capture)
// - Mode 111: sleep/idle rising-edge interrupt only
// - Wake mode ignores all other settings
// - Mode 110 unused, channel disabled
// - Mode 101 captures every 16th rise
// - Mode 000 switches channel off
`timescale 1ns/1ps
`default_nettype none
`include "icc_consts.svh"
module icc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic capture_channel,
    input wire icc_pkg::icc_timers_type timers,
    input wire icc_pkg::icc_cpu_type cpu,
    output logic capture_irq
);
    // ==========================================
    // Control register and fields
    localparam logic [15:0] ctrl_wmask = `ICC_CTRL_WMASK;
    logic [15:0] ctrl_ff;
    icc_pkg::icc_mode_type mode;
    logic [2:0] tsel;
    logic [1:0] cpi;
    assign mode = icc_pkg::icc_mode_type'(ctrl_ff[`ICC_MODE_LSB +: 3]);
    assign tsel = ctrl_ff[`ICC_TSEL_LSB +: 3];
    assign cpi = ctrl_ff[`ICC_CPI_LSB +: 2];

    // ==========================================
    // Input edges
    logic rise;
    logic fall;
    icc_edge u_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(capture_channel),
        .rise(rise),
        .fall(fall)
    );

    // ==========================================
    // Time base selection
    logic [15:0] tbase;
    always_comb begin
        unique case (tsel)
            icc_pkg::ICC_TSEL_T1: tbase = timers.t1;
            icc_pkg::ICC_TSEL_T5: tbase = timers.t5;
            icc_pkg::ICC_TSEL_T4: tbase = timers.t4;
            icc_pkg::ICC_TSEL_T2: tbase = timers.t2;
            icc_pkg::ICC_TSEL_T3: tbase = timers.t3;
            default: tbase = 16'h0000;
        endcase
    end

    // ==========================================
    // Capture event decode
    logic [3:0] pre_ff;
    logic active;
    logic cap_evt;
    logic run;
    // Idle stop disables the channel, clearing its buffer, while the core idles
    assign run = ~(ctrl_ff[`ICC_SIDL_BIT] & cpu.idle);
    assign active = run & (mode != icc_pkg::ICC_MODE_OFF)
        & (mode != icc_pkg::ICC_MODE_UNUSED) & (mode != icc_pkg::ICC_MODE_WAKE);
    always_comb begin
        unique case (mode)
            icc_pkg::ICC_MODE_BOTH: cap_evt = rise | fall;
            icc_pkg::ICC_MODE_FALL: cap_evt = fall;
            icc_pkg::ICC_MODE_RISE: cap_evt = rise;
            icc_pkg::ICC_MODE_RISE4: cap_evt = rise & (pre_ff == `ICC_PRESCALE_4);
            icc_pkg::ICC_MODE_RISE16: cap_evt = rise & (pre_ff == `ICC_PRESCALE_16);
            default: cap_evt = 1'b0;
        endcase
        cap_evt = cap_evt & active;
    end

    // Prescaler restarts whenever the channel stops or the mode is not a prescaled setting
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_ff <= 4'h0;
        end else if (!active || mode < icc_pkg::ICC_MODE_RISE4) begin
            pre_ff <= 4'h0;
        end else if (rise) begin
            if (cap_evt) begin
                pre_ff <= 4'h0;
            end else begin
                pre_ff <= pre_ff + 4'h1;
            end
        end
    end

    // ==========================================
    // Capture buffer (four words)
    logic [15:0] buf_ff [`ICC_BUF_DEPTH];
    logic [1:0] wp_ff;
    logic [1:0] rp_ff;
    logic [2:0] cnt_ff;
    logic ov_ff;
    logic pop;
    logic full;
    assign full = (cnt_ff == 3'h4);
    // Overflowed captures are dropped so the oldest data survive
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wp_ff <= 2'h0;
            rp_ff <= 2'h0;
            cnt_ff <= 3'h0;
            ov_ff <= 1'b0;
        end else if (!active) begin
            wp_ff <= 2'h0;
            rp_ff <= 2'h0;
            cnt_ff <= 3'h0;
            ov_ff <= 1'b0;
        end else begin
            if (cap_evt && full) begin
                ov_ff <= 1'b1;
            end
            if (cap_evt && !full) begin
                buf_ff[wp_ff] <= tbase;
                wp_ff <= wp_ff + 2'h1;
            end
            if (pop) begin
                rp_ff <= rp_ff + 2'h1;
            end
            cnt_ff <= cnt_ff + {2'h0, cap_evt && !full} - {2'h0, pop};
        end
    end

    // ==========================================
    // Captures-per-interrupt counter and interrupt
    logic [1:0] evc_ff;
    logic cpi_hit;
    logic wake_hit;
    assign cpi_hit = (mode == icc_pkg::ICC_MODE_BOTH) ? 1'b1 : (evc_ff == cpi);
    // Idle stop is one of the settings that wake mode disregards
    assign wake_hit = (mode == icc_pkg::ICC_MODE_WAKE) & rise
        & (cpu.sleep | cpu.idle);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evc_ff <= 2'h0;
        end else if (!active) begin
            evc_ff <= 2'h0;
        end else if (cap_evt) begin
            evc_ff <= cpi_hit ? 2'h0 : evc_ff + 2'h1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capture_irq <= 1'b0;
        end else begin
            capture_irq <= (cap_evt & cpi_hit) | wake_hit;
        end
    end

    // ==========================================
    // AXI4-Lite write channel
    logic aw_ok_ff;
    logic w_ok_ff;
    logic [3:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic wr_go;
    assign wr_go = aw_ok_ff & w_ok_ff & ~s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
            awaddr_ff <= 4'h0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ICC_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_ok_ff & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready <= ~w_ok_ff & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_ok_ff <= 1'b0;
                w_ok_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_ff == `ICC_CTRL_ADDR) ? `ICC_RESP_OKAY : `ICC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Flag bits are hardware owned; a write never reaches them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= `ICC_CTRL_RESET;
        end else if (wr_go && awaddr_ff == `ICC_CTRL_ADDR) begin
            if (wstrb_ff[0]) begin
                ctrl_ff[7:0] <= wdata_ff[7:0] & ctrl_wmask[7:0];
            end
            if (wstrb_ff[1]) begin
                ctrl_ff[15:8] <= wdata_ff[15:8] & ctrl_wmask[15:8];
            end
        end
    end

    // ==========================================
    // AXI4-Lite read channel
    logic [15:0] status;
    always_comb begin
        status = ctrl_ff;
        status[`ICC_OV_BIT] = ov_ff;
        status[`ICC_BNE_BIT] = (cnt_ff != 3'h0);
    end
    assign pop = s_axi_arvalid & s_axi_arready & (s_axi_araddr == `ICC_DATA_ADDR)
        & (cnt_ff != 3'h0);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ICC_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `ICC_RESP_OKAY;
                unique case (s_axi_araddr)
                    `ICC_CTRL_ADDR: s_axi_rdata <= {16'h0000, status};
                    `ICC_DATA_ADDR: s_axi_rdata <= {16'h0000, buf_ff[rp_ff]};
                    `ICC_TIMER_ADDR: s_axi_rdata <= {16'h0000, tbase};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `ICC_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================
    // Checks
    a_off_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        mode == icc_pkg::ICC_MODE_OFF |=> !capture_irq)
        else $error("irq while channel off");
    a_unused_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        mode == icc_pkg::ICC_MODE_UNUSED |=> cnt_ff == 3'h0)
        else $error("buffer filled in unused mode");
    a_rise_cap: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode == icc_pkg::ICC_MODE_RISE && rise && active && !full) |=> cnt_ff != 3'h0)
        else $error("rising edge not captured");
    a_fall_skip: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode == icc_pkg::ICC_MODE_FALL && rise && !fall) |-> !cap_evt)
        else $error("rise captured in falling mode");
    a_pre16_cnt: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode == icc_pkg::ICC_MODE_RISE16 && cap_evt) |-> pre_ff == 4'hF)
        else $error("prescale not sixteen");
    a_cpi_four: assert property (@(posedge aclk) disable iff (!aresetn)
        (cap_evt && mode != icc_pkg::ICC_MODE_BOTH && cpi == 2'h3 && evc_ff != 2'h3)
        |=> !capture_irq)
        else $error("early irq on fourth");
    a_cpi_three: assert property (@(posedge aclk) disable iff (!aresetn)
        (cap_evt && mode != icc_pkg::ICC_MODE_BOTH && cpi == 2'h2 && evc_ff == 2'h2)
        |=> capture_irq)
        else $error("missing irq on third");
    a_cpi_two: assert property (@(posedge aclk) disable iff (!aresetn)
        (cap_evt && mode != icc_pkg::ICC_MODE_BOTH && cpi == 2'h1 && evc_ff == 2'h1)
        |=> capture_irq && evc_ff == 2'h0)
        else $error("missing irq on second");
    a_both_every: assert property (@(posedge aclk) disable iff (!aresetn)
        (cap_evt && mode == icc_pkg::ICC_MODE_BOTH) |=> capture_irq)
        else $error("both-edge mode used count");
    a_wake_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode == icc_pkg::ICC_MODE_WAKE && rise && (cpu.sleep || cpu.idle)) |=> capture_irq)
        else $error("wake edge lost");
    a_wake_nocap: assert property (@(posedge aclk) disable iff (!aresetn)
        mode == icc_pkg::ICC_MODE_WAKE |-> !cap_evt)
        else $error("capture in wake mode");
    a_ov_set: assert property (@(posedge aclk) disable iff (!aresetn)
        (cap_evt && full) |=> ov_ff)
        else $error("overflow not flagged");
    a_t1_base: assert property (@(posedge aclk) disable iff (!aresetn)
        tsel == 3'h4 |-> tbase == timers.t1)
        else $error("wrong time base");
    a_t5_base: assert property (@(posedge aclk) disable iff (!aresetn)
        tsel == 3'h3 |-> tbase == timers.t5)
        else $error("wrong time base");
    c_capture: cover property (@(posedge aclk) cap_evt);
    c_overflow: cover property (@(posedge aclk) cap_evt && full);
    c_wake: cover property (@(posedge aclk) wake_hit);
    c_pop: cover property (@(posedge aclk) pop);
endmodule : icc_top
`default_nettype wire

// *** tb/icc_far.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Far side: capture pin and timer sources
module icc_far (
    input wire logic aclk,
    output logic capture_channel,
    output var icc_pkg::icc_timers_type timers
);
    // Timers move only on request so each captured value is known exactly
    initial timers = {16'h1A1A, 16'h2B2B, 16'h3C3C, 16'h4D4D, 16'h5E5E};
    initial capture_channel = 1'b0;
    task step_timers;
        @(posedge aclk);
        timers <= {16'h1B1B, 16'h2C2C, 16'h3D3D, 16'h4E4E, 16'h5F5F};
    endtask : step_timers
    task pulses(input int n);
        repeat (n) begin
            @(posedge aclk) capture_channel <= 1'b1;
            repeat (4) @(posedge aclk);
            capture_channel <= 1'b0;
            repeat (6) @(posedge aclk);
        end
    endtask : pulses
    task level(input logic v);
        @(posedge aclk) capture_channel <= v;
        repeat (8) @(posedge aclk);
    endtask : level
endmodule : icc_far
`default_nettype wire

// *** tb/tb_input_capture_channel_control.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "icc_consts.svh"
module tb_input_capture_channel_control;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, capture_channel, capture_irq;
    logic [1:0] bresp, rresp;
    icc_pkg::icc_timers_type timers;
    icc_pkg::icc_cpu_type cpu = 2'h0;
    int n_errors = 0, n_compared = 0, n_irq = 0, base = 0, cycles = 0;
    logic [31:0] d;
    logic [1:0] r;
    always #4 aclk = ~aclk;
    icc_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .capture_channel(capture_channel), .timers(timers),
        .cpu(cpu), .capture_irq(capture_irq));
    icc_far i_far (.aclk(aclk), .capture_channel(capture_channel), .timers(timers));
    always @(posedge aclk) begin
        if (capture_irq === 1'b1) n_irq <= n_irq + 1;
    end
    // ==========================================
    // Bus tasks
    task wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s,
        output logic [1:0] resp);
        logic aw_done;
        logic w_done;
        logic b_done;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_done = 1'b0;
        w_done = 1'b0;
        b_done = 1'b0;
        // Each channel is released at the edge that takes it, never before
        while (!b_done) begin
            @(posedge aclk);
            if (!aw_done && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                b_done = 1'b1;
                resp = bresp;
                bready <= 1'b0;
            end
        end
    endtask : wr
    task rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
        logic ar_done;
        logic r_done;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        ar_done = 1'b0;
        r_done = 1'b0;
        while (!r_done) begin
            @(posedge aclk);
            if (!ar_done && arready) begin
                ar_done = 1'b1;
                arvalid <= 1'b0;
            end
            if (rvalid) begin
                r_done = 1'b1;
                v = rdata;
                resp = rresp;
                rready <= 1'b0;
            end
        end
    endtask : rd
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Clearing first also resets the buffer and the per-interrupt count
    task cfg(input logic [2:0] m, input logic [1:0] c, input logic [2:0] t);
        wr(`ICC_CTRL_ADDR, 32'h0, 4'h3, r);
        wr(`ICC_CTRL_ADDR, {16'h0, 3'h0, t, 3'h0, c, 2'h0, m}, 4'h3, r);
        base = n_irq;
    endtask : cfg
    task flags(input logic ov, input logic bne);
        rd(`ICC_CTRL_ADDR, d, r);
        check({30'h0, d[4:3]}, {30'h0, ov, bne});
    endtask : flags
    task irqs(input int n);
        check(n_irq - base, n);
    endtask : irqs
    task tally_and_finish;
        if (n_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    // ==========================================
    // Tests
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`ICC_CTRL_ADDR, d, r);
        check(d, 32'h0);
        wr(`ICC_CTRL_ADDR, 32'hFFFF, 4'h1, r);
        rd(`ICC_CTRL_ADDR, d, r);
        check(d, 32'h0067);
        wr(`ICC_CTRL_ADDR, 32'hFFFF, 4'h3, r);
        rd(`ICC_CTRL_ADDR, d, r);
        check(d, 32'h3C67);
        cfg(3'h4, 2'h0, 3'h4);
        rd(`ICC_TIMER_ADDR, d, r);
        check(d, 32'h1A1A);
        cfg(3'h3, 2'h0, 3'h3);
        rd(`ICC_TIMER_ADDR, d, r);
        check(d, 32'h5E5E);
        cfg(3'h2, 2'h0, 3'h2);
        rd(`ICC_TIMER_ADDR, d, r);
        check(d, 32'h4D4D);
        cfg(3'h3, 2'h0, 3'h3);
        i_far.pulses(1);
        flags(1'b0, 1'b1);
        irqs(1);
        rd(`ICC_DATA_ADDR, d, r);
        check(d, 32'h5E5E);
        flags(1'b0, 1'b0);
        cfg(3'h5, 2'h0, 3'h3);
        i_far.pulses(15);
        flags(1'b0, 1'b0);
        i_far.pulses(1);
        flags(1'b0, 1'b1);
        cfg(3'h4, 2'h0, 3'h4);
        i_far.pulses(3);
        flags(1'b0, 1'b0);
        i_far.pulses(1);
        flags(1'b0, 1'b1);
        rd(`ICC_DATA_ADDR, d, r);
        check(d, 32'h1A1A);
        cfg(3'h2, 2'h0, 3'h3);
        i_far.level(1'b1);
        flags(1'b0, 1'b0);
        i_far.level(1'b0);
        flags(1'b0, 1'b1);
        cfg(3'h1, 2'h3, 3'h3);
        i_far.pulses(1);
        irqs(2);
        cfg(3'h0, 2'h0, 3'h3);
        i_far.pulses(2);
        flags(1'b0, 1'b0);
        irqs(0);
        cfg(3'h6, 2'h0, 3'h3);
        i_far.pulses(2);
        flags(1'b0, 1'b0);
        irqs(0);
        for (int c = 1; c < 4; c++) begin
            cfg(3'h3, c[1:0], 3'h3);
            i_far.pulses(c);
            irqs(0);
            i_far.pulses(1);
            irqs(1);
        end
        cfg(3'h3, 2'h0, 3'h3);
        i_far.pulses(5);
        flags(1'b1, 1'b1);
        cfg(3'h7, 2'h3, 3'h4);
        i_far.pulses(1);
        irqs(0);
        cpu <= 2'h2;
        i_far.pulses(1);
        irqs(1);
        flags(1'b0, 1'b0);
        cpu <= 2'h1;
        i_far.pulses(1);
        irqs(2);
        wr(`ICC_CTRL_ADDR, 32'h3C67, 4'h3, r);
        i_far.pulses(1);
        irqs(3);
        cpu <= 2'h0;
        i_far.step_timers();
        cfg(3'h3, 2'h0, 3'h3);
        rd(`ICC_TIMER_ADDR, d, r);
        check(d, 32'h5F5F);
        wr(4'hC, 32'h1, 4'h3, r);
        check({30'h0, r}, {30'h0, `ICC_RESP_SLVERR});
        rd(4'hC, d, r);
        check({30'h0, r}, {30'h0, `ICC_RESP_SLVERR});
        tally_and_finish();
    end
endmodule : tb_input_capture_channel_control
`default_nettype wire
